// [include/hwk_pkg.sv]
/*
 * hwk_pkg: constants shared by the host MAC wake-up control block.
 * Assumes a 32-bit APB slave with a word index times four as byte address.
 */
package hwk_pkg;

    // apb geometry
    localparam int          APB_ADDR_W        = 12;
    localparam int          APB_DATA_W        = 32;
    localparam logic [31:0] APB_BYTES_PER_REG = 32'h0000_0004;

    // register indices as printed; byte address is four times the index
    localparam logic [31:0] IDX_WAKE_FILTER   = 32'h0000_000B;
    localparam logic [31:0] IDX_WAKE_CTRL     = 32'h0000_000C;
    localparam logic [APB_ADDR_W-1:0] ADDR_WAKE_FILTER =
        APB_ADDR_W'(IDX_WAKE_FILTER * APB_BYTES_PER_REG);
    localparam logic [APB_ADDR_W-1:0] ADDR_WAKE_CTRL   =
        APB_ADDR_W'(IDX_WAKE_CTRL * APB_BYTES_PER_REG);

    // wake_control_status field positions
    localparam int          BIT_MAGIC_EN      = 1;
    localparam int          BIT_FRAME_EN      = 2;
    localparam int          BIT_MAGIC_RCVD    = 5;
    localparam int          BIT_FRAME_RCVD    = 6;
    localparam int          BIT_UCAST_EN      = 9;
    localparam logic [31:0] WAKE_CTRL_RESET   = 32'h0000_0000;
    localparam logic [31:0] READ_ZERO         = 32'h0000_0000;

    // wake-up frame filter storage
    localparam int          FILTER_WORDS      = 8;
    localparam int          FILTER_PTR_W      = 3;
    localparam logic [FILTER_PTR_W-1:0] FILTER_PTR_RESET = 3'h0;
    localparam logic [FILTER_PTR_W-1:0] FILTER_PTR_LAST  = 3'h7;
    localparam logic [FILTER_PTR_W-1:0] FILTER_PTR_STEP  = 3'h1;

    // destination address class
    localparam int          MAC_ADDR_W        = 48;
    localparam logic [1:0]  UCAST_GLOBAL_BITS = 2'h0;

endpackage

// [include/hwk_filter_if.sv]
/*
 * hwk_filter_if: write and read signals between the wake control logic
 * and the filter word memory. Assumes both ends run on pclk.
 */
`timescale 1ns/1ps
interface hwk_filter_if;
    import hwk_pkg::*;

    logic                    wr_en;
    logic [FILTER_PTR_W-1:0] wr_index;
    logic [APB_DATA_W-1:0]   wr_data;
    logic [FILTER_PTR_W-1:0] rd_index;
    logic [APB_DATA_W-1:0]   rd_data;

    modport ctrl (output wr_en, output wr_index, output wr_data, output rd_index,
                  input rd_data);
    modport mem  (input wr_en, input wr_index, input wr_data, input rd_index,
                  output rd_data);
endinterface

// [design/hwk_filter_mem.sv]
/*
 * hwk_filter_mem: eight 32-bit wake-up filter words, registered read port.
 * Assumes writes and reads arrive from logic on pclk.
 */
`timescale 1ns/1ps
module hwk_filter_mem
    import hwk_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    hwk_filter_if.mem bus
);
    logic [APB_DATA_W-1:0] word_reg [FILTER_WORDS];
    logic [APB_DATA_W-1:0] rd_data_reg;

    assign bus.rd_data = rd_data_reg;

    // storage; words clear at reset so the matcher never sees junk
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < FILTER_WORDS; i++)
                word_reg[i] <= READ_ZERO;
        end
        else if (bus.wr_en)
        begin
            word_reg[bus.wr_index] <= bus.wr_data;
        end
    end

    // read data one cycle after the index
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rd_data_reg <= READ_ZERO;
        else
            rd_data_reg <= word_reg[bus.rd_index];
    end
endmodule // hwk_filter_mem

// [design/hwk_event_flag.sv]
/*
 * hwk_event_flag: one sticky status bit set by hardware, cleared by software.
 * Assumes set and clr are single-cycle terms on pclk.
 */
`timescale 1ns/1ps
module hwk_event_flag
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic set,
    input  wire logic clr,
    output wire logic flag,
    output wire logic rise
);
    logic flag_reg;
    logic flag_next;

    // set beats clear so a colliding event is never lost
    assign flag_next = set ? 1'b1 : (clr ? 1'b0 : flag_reg);
    assign rise      = set & ~flag_reg;
    assign flag      = flag_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flag_reg <= 1'b0;
        else
            flag_reg <= flag_next;
    end
endmodule // hwk_event_flag

// [design/hwk_wake_ctrl.sv]
/*
 * hwk_wake_ctrl: wake-up control and status of the host MAC, APB slave with
 * the control/status register and the write-only filter port, and the
 * qualifier logic fed by the receive path.
 * Assumes the receive path runs on pclk and gives one end-of-frame pulse per
 * frame with address, good status and match results valid in that cycle.
 */
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module hwk_wake_ctrl
(
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [hwk_pkg::APB_ADDR_W-1:0] paddr,
    input  wire logic [hwk_pkg::APB_DATA_W-1:0] pwdata,
    output wire logic [hwk_pkg::APB_DATA_W-1:0] prdata,
    output wire logic                          pready,
    output wire logic                          pslverr,
    input  wire logic                          power_save,
    input  wire logic                          rx_frame_end,
    input  wire logic                          rx_frame_ok,
    input  wire logic [hwk_pkg::MAC_ADDR_W-1:0] rx_dest_addr,
    input  wire logic                          rx_filter_match,
    input  wire logic                          rx_magic_match,
    input  wire logic [hwk_pkg::FILTER_PTR_W-1:0] filter_rd_index,
    output wire logic [hwk_pkg::APB_DATA_W-1:0] filter_rd_data,
    output wire logic                          wake_event
);
    import hwk_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // declarations
    logic                    magic_packet_enable_reg;
    logic                    wake_frame_enable_reg;
    logic                    global_unicast_wake_enable_reg;
    logic [FILTER_PTR_W-1:0] filter_ptr_reg;
    logic [FILTER_PTR_W-1:0] filter_ptr_next;
    logic [APB_DATA_W-1:0]   prdata_reg;
    logic                    wake_event_reg;
    wire logic               wake_frame_received;
    wire logic               magic_packet_received;
    wire logic               frame_rise;
    wire logic               magic_rise;

    hwk_filter_if filt ();

    ////////////////////////////////////////////////////////////////////////
    // apb decode; zero wait states, so an access phase is always final
    wire logic setup_phase  = psel & ~penable;
    wire logic access_phase = psel & penable;
    wire logic hit_ctrl     = (paddr == ADDR_WAKE_CTRL);
    wire logic hit_filter   = (paddr == ADDR_WAKE_FILTER);
    wire logic mapped       = hit_ctrl | hit_filter;
    wire logic wr_ctrl      = access_phase & pwrite & hit_ctrl;
    wire logic wr_filter    = access_phase & pwrite & hit_filter;

    assign pready  = 1'b1;
    assign pslverr = access_phase & ~mapped; // unmapped addresses error out
    assign prdata  = prdata_reg;

    // write-one-to-clear strobes for the sticky bits
    wire logic clr_frame = wr_ctrl & pwdata[BIT_FRAME_RCVD];
    wire logic clr_magic = wr_ctrl & pwdata[BIT_MAGIC_RCVD];

    ////////////////////////////////////////////////////////////////////////
    // wake qualifiers from the receive path
    wire logic rx_qualify = power_save & rx_frame_end & rx_frame_ok;
    wire logic is_global_ucast = (rx_dest_addr[1:0] == UCAST_GLOBAL_BITS);
    wire logic filt_hit  = rx_qualify & wake_frame_enable_reg & rx_filter_match;
    wire logic ucast_hit = rx_qualify & global_unicast_wake_enable_reg
                           & is_global_ucast;
    wire logic magic_hit = rx_qualify & magic_packet_enable_reg & rx_magic_match;
    // unicast feeds the same frame qualifier, not a separate path
    wire logic frame_set = filt_hit | ucast_hit;

    ////////////////////////////////////////////////////////////////////////
    // status flags
    hwk_event_flag u_frame_flag
    (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (frame_set),
        .clr     (clr_frame),
        .flag    (wake_frame_received),
        .rise    (frame_rise)
    );

    hwk_event_flag u_magic_flag
    (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (magic_hit),
        .clr     (clr_magic),
        .flag    (magic_packet_received),
        .rise    (magic_rise)
    );

    ////////////////////////////////////////////////////////////////////////
    // control bits of wake_control_status
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            magic_packet_enable_reg        <= WAKE_CTRL_RESET[BIT_MAGIC_EN];
            wake_frame_enable_reg          <= WAKE_CTRL_RESET[BIT_FRAME_EN];
            global_unicast_wake_enable_reg <= WAKE_CTRL_RESET[BIT_UCAST_EN];
        end
        else if (wr_ctrl)
        begin
            magic_packet_enable_reg        <= pwdata[BIT_MAGIC_EN];
            wake_frame_enable_reg          <= pwdata[BIT_FRAME_EN];
            global_unicast_wake_enable_reg <= pwdata[BIT_UCAST_EN];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read view; reserved bits read zero
    wire logic [APB_DATA_W-1:0] ctrl_view =
        (APB_DATA_W'(magic_packet_enable_reg)        << BIT_MAGIC_EN)   |
        (APB_DATA_W'(wake_frame_enable_reg)          << BIT_FRAME_EN)   |
        (APB_DATA_W'(magic_packet_received)          << BIT_MAGIC_RCVD) |
        (APB_DATA_W'(wake_frame_received)            << BIT_FRAME_RCVD) |
        (APB_DATA_W'(global_unicast_wake_enable_reg) << BIT_UCAST_EN);
    // filter port is write-only, so it and unmapped space read zero
    wire logic [APB_DATA_W-1:0] rd_view = hit_ctrl ? ctrl_view : READ_ZERO;

    // capture in setup so prdata comes from a flop in the access phase;
    // a flag set during the setup cycle shows on the next read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_reg <= READ_ZERO;
        else if (setup_phase & ~pwrite)
            prdata_reg <= rd_view;
    end

    ////////////////////////////////////////////////////////////////////////
    // filter load pointer, wraps after the eighth word
    assign filter_ptr_next = (filter_ptr_reg == FILTER_PTR_LAST) ? FILTER_PTR_RESET
                           : filter_ptr_reg + FILTER_PTR_STEP;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            filter_ptr_reg <= FILTER_PTR_RESET;
        else if (wr_filter)
            filter_ptr_reg <= filter_ptr_next;
    end

    assign filt.wr_en    = wr_filter;
    assign filt.wr_index = filter_ptr_reg;
    assign filt.wr_data  = pwdata;
    assign filt.rd_index = filter_rd_index;
    assign filter_rd_data = filt.rd_data;

    hwk_filter_mem u_filter_mem
    (
        .pclk    (pclk),
        .presetn (presetn),
        .bus     (filt.mem)
    );

    ////////////////////////////////////////////////////////////////////////
    // wake event toward power management, one pulse per cycle in which a status bit newly sets
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wake_event_reg <= 1'b0;
        else
            wake_event_reg <= frame_rise | magic_rise;
    end

    assign wake_event = wake_event_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_unicast_wakes: assert property (ucast_hit && !wake_frame_received
                                      && !magic_packet_received
                                      |=> wake_event)
        else $error("global unicast did not raise a wake event");

    a_unicast_class: assert property (
        $rose(wake_frame_received) && !$past(filt_hit)
        |-> $past(is_global_ucast))
        else $error("frame flag set by a non unicast address");

    a_frame_sticky: assert property (wake_frame_received && !clr_frame
                                     |=> wake_frame_received)
        else $error("frame received bit dropped without a clear");

    a_frame_clear: assert property (wake_frame_received && clr_frame && !frame_set
                                    |=> !wake_frame_received)
        else $error("frame received bit not cleared by write");

    a_magic_sets: assert property (magic_hit |=> magic_packet_received)
        else $error("magic packet did not set its status bit");

    a_magic_clear: assert property (magic_packet_received && clr_magic && !magic_hit
                                    |=> !magic_packet_received)
        else $error("magic received bit not cleared by write");

    a_filter_gated: assert property (
        $rose(wake_frame_received) && !$past(ucast_hit)
        |-> $past(wake_frame_enable_reg))
        else $error("filter match counted while frame wake disabled");

    a_magic_gated: assert property (
        $rose(magic_packet_received) |-> $past(magic_packet_enable_reg))
        else $error("magic packet counted while magic wake disabled");

    a_unicast_path: assert property (ucast_hit |=> wake_frame_received)
        else $error("unicast qualifier did not reach the frame flag");

    a_ptr_wrap: assert property (wr_filter && filter_ptr_reg == FILTER_PTR_LAST
                                 |=> filter_ptr_reg == FILTER_PTR_RESET)
        else $error("filter pointer did not wrap after eighth word");

    a_ptr_hold: assert property (!wr_filter |=> $stable(filter_ptr_reg))
        else $error("filter pointer moved without a filter write");

    a_wake_pulse: assert property (
        wake_event |-> $rose(wake_frame_received) || $rose(magic_packet_received)
        ##1 !wake_event || $rose(wake_frame_received)
        || $rose(magic_packet_received))
        else $error("wake event without a newly set status bit");

    ////////////////////////////////////////////////////////////////////////
    // gating, write paths and set-over-clear priority

    // a magic packet alone must also reach power management
    a_magic_wakes: assert property (magic_hit && !wake_frame_received
                                    && !magic_packet_received |=> wake_event)
        else $error("magic packet did not raise a wake event");

    // no new status bit, no pulse toward power management
    a_wake_quiet: assert property (!frame_rise && !magic_rise
                                   |=> !wake_event)
        else $error("wake event without a rising status bit");

    // set beats clear, so an event in the clearing cycle is kept
    a_frame_set_wins: assert property (frame_set && clr_frame
                                       |=> wake_frame_received)
        else $error("frame event lost to a clear in the same cycle");

    a_magic_set_wins: assert property (magic_hit && clr_magic
                                       |=> magic_packet_received)
        else $error("magic event lost to a clear in the same cycle");

    a_magic_sticky: assert property (magic_packet_received && !clr_magic
                                     |=> magic_packet_received)
        else $error("magic received bit dropped without a clear");

    // outside power saving nothing may set a received bit
    a_sleep_gated: assert property (!power_save
        |=> !$rose(wake_frame_received) && !$rose(magic_packet_received))
        else $error("received bit set outside power saving");

    a_frame_quals_off: assert property (!wake_frame_enable_reg
        && !global_unicast_wake_enable_reg |=> !$rose(wake_frame_received))
        else $error("frame bit set with every frame qualifier disabled");

    a_magic_off: assert property (!magic_packet_enable_reg
                                  |=> !$rose(magic_packet_received))
        else $error("magic bit set while magic wake disabled");

    // enables follow the written word at the access edge
    a_frame_en_write: assert property (wr_ctrl
        |=> wake_frame_enable_reg == $past(pwdata[BIT_FRAME_EN]))
        else $error("frame enable did not take the written value");

    a_magic_en_write: assert property (wr_ctrl
        |=> magic_packet_enable_reg == $past(pwdata[BIT_MAGIC_EN]))
        else $error("magic enable did not take the written value");

    a_ucast_en_write: assert property (wr_ctrl
        |=> global_unicast_wake_enable_reg == $past(pwdata[BIT_UCAST_EN]))
        else $error("unicast enable did not take the written value");

    // read data in the access phase show the enable of the setup cycle
    a_ucast_readback: assert property (access_phase && !pwrite && hit_ctrl
        |-> prdata[BIT_UCAST_EN] == $past(global_unicast_wake_enable_reg))
        else $error("read data disagree with the unicast enable");

    // below the last word the pointer moves by exactly one
    a_ptr_step: assert property (wr_filter && filter_ptr_reg != FILTER_PTR_LAST
        |=> filter_ptr_reg == $past(filter_ptr_reg) + FILTER_PTR_STEP)
        else $error("filter pointer did not step by one word");

    c_unicast_wake: cover property (ucast_hit ##1 wake_event);
    c_magic_wake:   cover property (magic_hit ##1 wake_event);
    c_ptr_wrap:     cover property (wr_filter && filter_ptr_reg == FILTER_PTR_LAST);
    c_clear_clash:  cover property (frame_set && clr_frame && wake_frame_received);
    c_filter_wake:  cover property (filt_hit ##1 wake_event);

endmodule // hwk_wake_ctrl

// [tb/hwk_rx_model.sv]
/*
 * hwk_rx_model: stand-in for the receive path, one end-of-frame pulse per send.
 * Assumes the caller enters send right after a rising pclk edge.
 */
`timescale 1ns/1ps
module hwk_rx_model
(
    input  wire logic                       pclk,
    output logic                            rx_frame_end,
    output logic                            rx_frame_ok,
    output logic [hwk_pkg::MAC_ADDR_W-1:0]  rx_dest_addr,
    output logic                            rx_filter_match,
    output logic                            rx_magic_match
);
    import hwk_pkg::*;

    logic                  busy  = 1'b0;
    logic [MAC_ADDR_W-1:0] noise = 48'h0;

    initial
    begin
        rx_frame_end    = 1'b0;
        rx_frame_ok     = 1'b0;
        rx_dest_addr    = 48'h0;
        rx_filter_match = 1'b0;
        rx_magic_match  = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // between frames the side lines churn, so stale values never look valid
    always @(posedge pclk)
    begin
        if (!busy)
        begin
            // johnson step; a plain shift would stick at zero
            noise           <= {noise[MAC_ADDR_W-2:0], ~noise[MAC_ADDR_W-1]};
            rx_dest_addr    <= noise;
            rx_frame_ok     <= noise[2];
            rx_filter_match <= noise[0];
            rx_magic_match  <= noise[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // one frame end; returns at the edge that samples the pulse
    task automatic send(input logic ok, input logic [1:0] lo, input logic fm, input logic mm);
        // busy goes up one edge early so the churn never races the frame
        busy            <= 1'b1;
        @(posedge pclk);
        rx_frame_end    <= 1'b1;
        rx_frame_ok     <= ok;
        rx_dest_addr    <= {46'h1234_5678_9ABC, lo};
        rx_filter_match <= fm;
        rx_magic_match  <= mm;
        @(posedge pclk);
        rx_frame_end    <= 1'b0;
        busy            <= 1'b0;
    endtask
endmodule // hwk_rx_model

// [tb/host_mac_wakeup_control_test.sv]
/*
 * host_mac_wakeup_control_test: self-checking bench for hwk_wake_ctrl.
 * Assumes hwk_rx_model drives the receive side on the same pclk.
 */
`timescale 1ns/1ps
module host_mac_wakeup_control_test;
    import hwk_pkg::*;

    logic                    pclk            = 1'b0;
    logic                    presetn         = 1'b0;
    logic                    psel            = 1'b0;
    logic                    penable         = 1'b0;
    logic                    pwrite          = 1'b0;
    logic [APB_ADDR_W-1:0]   paddr           = 12'h0;
    logic [APB_DATA_W-1:0]   pwdata          = 32'h0;
    logic                    power_save      = 1'b0;
    logic [FILTER_PTR_W-1:0] filter_rd_index = 3'h0;
    logic [APB_DATA_W-1:0]   prdata;
    logic [APB_DATA_W-1:0]   filter_rd_data;
    logic                    pready;
    logic                    pslverr;
    logic                    wake_event;
    logic                    rx_frame_end;
    logic                    rx_frame_ok;
    logic [MAC_ADDR_W-1:0]   rx_dest_addr;
    logic                    rx_filter_match;
    logic                    rx_magic_match;
    logic [31:0]             rd;
    logic                    err;
    int                      fail_count      = 0;
    int                      n_tests         = 0;

    // case table: control, {ok, power_save, addr low, filter, magic}, status set
    localparam logic [9:0] C_CTRL [11] = '{10'h200, 10'h200, 10'h200, 10'h200, 10'h004,
        10'h000, 10'h002, 10'h000, 10'h206, 10'h206, 10'h206};
    localparam logic [5:0] C_STIM [11] = '{6'h30, 6'h34, 6'h38, 6'h3C, 6'h36, 6'h36,
        6'h35, 6'h35, 6'h13, 6'h23, 6'h31};
    localparam logic [9:0] C_EXP [11] = '{10'h040, 10'h000, 10'h000, 10'h000, 10'h040,
        10'h000, 10'h020, 10'h000, 10'h000, 10'h000, 10'h060};

    always #5 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////////////
    hwk_wake_ctrl u_hwk_wake_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .power_save(power_save),
        .rx_frame_end(rx_frame_end), .rx_frame_ok(rx_frame_ok), .rx_dest_addr(rx_dest_addr),
        .rx_filter_match(rx_filter_match), .rx_magic_match(rx_magic_match),
        .filter_rd_index(filter_rd_index), .filter_rd_data(filter_rd_data),
        .wake_event(wake_event));

    hwk_rx_model u_hwk_rx_model (.pclk(pclk), .rx_frame_end(rx_frame_end),
        .rx_frame_ok(rx_frame_ok), .rx_dest_addr(rx_dest_addr),
        .rx_filter_match(rx_filter_match), .rx_magic_match(rx_magic_match));

    ////////////////////////////////////////////////////////////////////////////
    // compare and count; x or z never matches
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // one apb transfer, entered just after a rising edge; held until pready
    task automatic apb_xfer(input logic wr, input logic [APB_ADDR_W-1:0] a,
                            input logic [31:0] d, output logic [31:0] r, output logic e);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic apb_write(input logic [APB_ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb_xfer(1'b1, a, d, r, e);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // watchdog: the sequence needs well under a thousand cycles
    initial
    begin
        #200000;
        fail_count++;
        give_verdict();
    end

    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb_xfer(1'b0, ADDR_WAKE_CTRL, 32'h0, rd, err);
        check(rd, 32'h0000_0000);
        check({31'h0, err}, 32'h0);
        check({31'h0, pready}, 32'h1);
        // reserved and received bits must not stick from an all-ones write
        apb_write(ADDR_WAKE_CTRL, 32'hFFFF_FFFF);
        apb_xfer(1'b0, ADDR_WAKE_CTRL, 32'h0, rd, err);
        check(rd, 32'h0000_0206);
        apb_xfer(1'b0, 12'h040, 32'h0, rd, err);
        check({rd[30:0], err}, 32'h0000_0001);
        apb_xfer(1'b0, ADDR_WAKE_FILTER, 32'h0, rd, err);
        check({rd[30:0], err}, 32'h0000_0000);
        // qualifier table, old status cleared by writing ones first
        for (int i = 0; i < 11; i++)
        begin
            apb_write(ADDR_WAKE_CTRL, {22'h0, C_CTRL[i]} | 32'h0000_0060);
            power_save <= C_STIM[i][4];
            u_hwk_rx_model.send(C_STIM[i][5], C_STIM[i][3:2], C_STIM[i][1], C_STIM[i][0]);
            #1;
            check({31'h0, wake_event}, {31'h0, C_EXP[i] != 10'h0});
            @(posedge pclk);
            #1;
            check({31'h0, wake_event}, 32'h0);
            apb_xfer(1'b0, ADDR_WAKE_CTRL, 32'h0, rd, err);
            check(rd, {22'h0, C_CTRL[i] | C_EXP[i]});
        end
        // bits already set: no new wake pulse, then clear magic only
        u_hwk_rx_model.send(1'b1, 2'h0, 1'b1, 1'b1);
        #1;
        check({31'h0, wake_event}, 32'h0);
        apb_write(ADDR_WAKE_CTRL, 32'h0000_0226);
        apb_xfer(1'b0, ADDR_WAKE_CTRL, 32'h0, rd, err);
        check(rd, 32'h0000_0246);
        // a clear that meets a new frame in one cycle loses to the set
        fork
            apb_write(ADDR_WAKE_CTRL, 32'h0000_0266);
            u_hwk_rx_model.send(1'b1, 2'h0, 1'b0, 1'b0);
        join
        apb_xfer(1'b0, ADDR_WAKE_CTRL, 32'h0, rd, err);
        check(rd, 32'h0000_0246);
        // nine filter writes: the ninth lands on word zero again
        for (int i = 0; i < 9; i++)
            apb_write(ADDR_WAKE_FILTER, 32'hA5A5_0000 + 32'(i));
        for (int k = 0; k < 8; k++)
        begin
            filter_rd_index <= 3'(k);
            @(posedge pclk);
            #1;
            check(filter_rd_data, 32'hA5A5_0000 + 32'((k == 0) ? 8 : k));
        end
        // mid-run reset: status, words and the load pointer back to zero
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb_xfer(1'b0, ADDR_WAKE_CTRL, 32'h0, rd, err);
        check(rd, 32'h0000_0000);
        check(filter_rd_data, 32'h0000_0000);
        apb_write(ADDR_WAKE_FILTER, 32'h5A5A_0001);
        filter_rd_index <= 3'h0;
        @(posedge pclk);
        #1;
        check(filter_rd_data, 32'h5A5A_0001);
        give_verdict();
    end
endmodule // host_mac_wakeup_control_test
